// *** rtl/asfo_regs.vh ***
// Purpose: Register offsets, fields and reset values of the sample buffer block
// Assumes: Byte-wide register port inside the device
// Notes:   Definitions only
`ifndef ASFO_REGS_VH
`define ASFO_REGS_VH
`define ASFO_ADDR_STATUS   8'h00
`define ASFO_ADDR_XH       8'h01
`define ASFO_ADDR_XL       8'h02
`define ASFO_ADDR_YH       8'h03
`define ASFO_ADDR_YL       8'h04
`define ASFO_ADDR_ZH       8'h05
`define ASFO_ADDR_ZL       8'h06
`define ASFO_ADDR_FSTAT    8'h08
`define ASFO_ADDR_SETUP    8'h09
`define ASFO_ADDR_CFG      8'h0e
`define ASFO_MODE_OFF      2'b00
`define ASFO_MODE_CIRC     2'b01
`define ASFO_MODE_STOP     2'b10
`define ASFO_MODE_TRIG     2'b11
`define ASFO_SETUP_RESET   8'h00
`define ASFO_CFG_RESET     8'h00
`define ASFO_CFG_HPF_BIT   4
`define ASFO_FS_RSVD       2'b11
`define ASFO_DEPTH         32
`endif

// *** rtl/asfo_fifo.v ***
// Purpose: Small valid/ready FIFO in the sample path
// Assumes: One clock, synchronous active-low reset
// Notes:   Flush empties it in one cycle
`timescale 1ns/1ps
module asfo_fifo #(
  parameter WIDTH = 42,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;
  always @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge sys_clk) begin
    if (!rst_n || flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // asfo_fifo

// *** rtl/asfo_core.v ***
// Purpose: Axis output registers, 32-sample buffer, buffer setup and data config
// Assumes: Byte register port driven by the serial interface logic on sys_clk
// Notes:   Samples arrive as 14-bit triples with a strobe at the selected rate
`timescale 1ns/1ps
`include "asfo_regs.vh"
module asfo_core #(
  parameter DEPTH = 32,
  parameter CW    = 6
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        sample_valid,
  output wire        sample_ready,
  input  wire [13:0] raw_x,
  input  wire [13:0] raw_y,
  input  wire [13:0] raw_z,
  input  wire [13:0] hpf_x,
  input  wire [13:0] hpf_y,
  input  wire [13:0] hpf_z,
  input  wire        fast_read,
  input  wire        rate_change,
  input  wire        go_active,
  input  wire        sleep_enter,
  input  wire        sleep_gate,
  input  wire        trigger_in,
  input  wire        reg_rd,
  input  wire        reg_burst,
  input  wire        reg_wr,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg  [7:0]  next_addr,
  output reg  [1:0]  full_scale_select,
  output reg         hpf_select,
  output reg         gate_error,
  output reg         data_ready_status
);
  reg  [41:0]   mem [0:DEPTH-1];
  reg  [4:0]    head;
  reg  [CW:0]   count;
  reg  [1:0]    mode;
  reg  [5:0]    wmark;
  reg           ovf;
  reg           wm_flag;
  reg           triggered;
  reg           frozen;
  reg  [41:0]   current;
  reg  [7:0]    next_rdata;
  reg  [7:0]    next_inc;
  wire [41:0]   in_word;
  wire          in_ok;
  wire [41:0]   fifo_out;
  wire          fifo_valid;
  wire          take;
  wire          buf_on;
  wire          pop;
  wire          flush;
  wire          stage_flush;
  wire          full;
  wire          mode_wr;
  wire [4:0]    tail;
  wire [41:0]   head_word;
  wire [CW:0]   count_after;

  assign in_word = hpf_select ? {hpf_x, hpf_y, hpf_z} : {raw_x, raw_y, raw_z};

  // Staging FIFO between acquisition and sample store
  asfo_fifo #(.WIDTH(42), .DEPTH(4), .AW(2)) u_stage (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .flush     (stage_flush),
    .in_data   (in_word),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (in_ok)
  );

  assign buf_on    = (mode != `ASFO_MODE_OFF);
  assign mode_wr   = reg_wr && (reg_addr == `ASFO_ADDR_SETUP);
  assign full      = (count == DEPTH[CW:0]);
  assign tail      = head + count[4:0];
  assign head_word = mem[head];
  assign pop       = reg_rd && buf_on && (reg_addr == `ASFO_ADDR_XH) && (count != 0);
  // Stop mode and post-trigger refuse new samples once full
  assign in_ok = !frozen && !(full && ((mode == `ASFO_MODE_STOP) ||
                 ((mode == `ASFO_MODE_TRIG) && triggered)));
  assign take  = fifo_valid && in_ok;
  assign flush = !buf_on || rate_change || go_active ||
                 (mode_wr && reg_wdata[7:6] == `ASFO_MODE_OFF);
  // Staging keeps flowing while the buffer is off so current samples still land
  assign stage_flush = rate_change || go_active;
  // Overwrite in circular mode pops implicitly
  assign count_after = (take && !(full && buf_on) && !pop) ? count + 1'b1 :
                       (pop && !take) ? count - 1'b1 : count;

  always @(posedge sys_clk) begin
    if (take && buf_on) begin
      mem[tail] <= fifo_out;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      mode              <= `ASFO_MODE_OFF;
      wmark             <= 6'h00;
      full_scale_select <= 2'h0;
      hpf_select        <= 1'b0;
      head              <= 5'h00;
      count             <= {(CW+1){1'b0}};
      ovf               <= 1'b0;
      wm_flag           <= 1'b0;
      triggered         <= 1'b0;
      frozen            <= 1'b0;
      gate_error        <= 1'b0;
      current           <= 42'h0;
      data_ready_status <= 1'b0;
    end else begin
      if (mode_wr) begin
        mode  <= reg_wdata[7:6];
        wmark <= reg_wdata[5:0];
      end
      if (reg_wr && reg_addr == `ASFO_ADDR_CFG) begin
        hpf_select <= reg_wdata[`ASFO_CFG_HPF_BIT];
        if (reg_wdata[1:0] != `ASFO_FS_RSVD) begin
          full_scale_select <= reg_wdata[1:0];
        end
      end
      if (take) begin
        current           <= fifo_out;
        data_ready_status <= 1'b1;
      end else if (reg_rd && reg_addr == `ASFO_ADDR_ZL) begin
        data_ready_status <= 1'b0;
      end
      if (sleep_enter && sleep_gate && buf_on) begin
        frozen     <= 1'b1;
        gate_error <= 1'b1;
      end else if (frozen && count == 0) begin
        frozen     <= 1'b0;
        gate_error <= 1'b0;
      end
      if (flush) begin
        head      <= 5'h00;
        count     <= {(CW+1){1'b0}};
        ovf       <= 1'b0;
        wm_flag   <= 1'b0;
        triggered <= 1'b0;
      end else begin
        if (take && full && !pop) begin
          head <= head + 1'b1;
        end else if (pop) begin
          head <= head + 1'b1;
        end
        count <= count_after;
        if (mode == `ASFO_MODE_TRIG && trigger_in) begin
          triggered <= 1'b1;
        end
        ovf     <= (count_after == DEPTH[CW:0]);
        wm_flag <= (wmark != 6'h00) && (count_after >= {1'b0, wmark});
      end
    end
  end

  always @* begin
    next_rdata = 8'h00;
    next_inc   = reg_addr + 8'h01;
    if (reg_addr == `ASFO_ADDR_STATUS) begin
      next_rdata = {7'h00, data_ready_status};
    end else if (reg_addr == `ASFO_ADDR_XH) begin
      next_rdata = buf_on ? head_word[41:34] : current[41:34];
    end else if (reg_addr == `ASFO_ADDR_XL) begin
      next_rdata = buf_on ? 8'h00 : {current[33:28], 2'b00};
    end else if (reg_addr == `ASFO_ADDR_YH) begin
      next_rdata = buf_on ? 8'h00 : current[27:20];
    end else if (reg_addr == `ASFO_ADDR_YL) begin
      next_rdata = buf_on ? 8'h00 : {current[19:14], 2'b00};
    end else if (reg_addr == `ASFO_ADDR_ZH) begin
      next_rdata = buf_on ? 8'h00 : current[13:6];
    end else if (reg_addr == `ASFO_ADDR_ZL) begin
      next_rdata = buf_on ? 8'h00 : {current[5:0], 2'b00};
    end else if (reg_addr == `ASFO_ADDR_FSTAT) begin
      next_rdata = {ovf, wm_flag, count[5:0]};
    end else if (reg_addr == `ASFO_ADDR_SETUP) begin
      next_rdata = {mode, wmark};
    end else if (reg_addr == `ASFO_ADDR_CFG) begin
      next_rdata = {3'h0, hpf_select, 2'h0, full_scale_select};
    end
    // Buffer head stays at 0x01; each read there while samples are stored pops one whole sample and returns its X high byte
    if (buf_on && reg_addr == `ASFO_ADDR_XH) begin
      next_inc = `ASFO_ADDR_XH;
    end else if (fast_read && reg_addr == `ASFO_ADDR_XH) begin
      next_inc = `ASFO_ADDR_YH;
    end else if (fast_read && reg_addr == `ASFO_ADDR_YH) begin
      next_inc = `ASFO_ADDR_ZH;
    end else if (reg_addr == `ASFO_ADDR_ZL || (fast_read && reg_addr == `ASFO_ADDR_ZH)) begin
      next_inc = `ASFO_ADDR_STATUS;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      next_addr <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
      next_addr <= reg_burst ? next_inc : reg_addr;
    end
  end
endmodule // asfo_core

// *** bench/asfo_core_assertions.sv ***
// Purpose: Register port timing checks of the sample buffer block
// Assumes: Buffer mode is tracked from writes to the setup register
// Notes:   Bound to asfo_core
`timescale 1ns/1ps
module asfo_chk (
  input wire       sys_clk,
  input wire       rst_n,
  input wire       reg_rd,
  input wire       reg_burst,
  input wire       reg_wr,
  input wire       fast_read,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [7:0] next_addr,
  input wire [1:0] full_scale_select,
  input wire       hpf_select
);
  reg  [1:0] mode;
  wire       brd = reg_rd && reg_burst && mode == 2'b00;
  always @(posedge sys_clk) begin
    if (!rst_n)
      mode <= 2'b00;
    else if (reg_wr && reg_addr == 8'h09)
      mode <= reg_wdata[7:6];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence cfg_wr;
    reg_wr && reg_addr == 8'h0e;
  endsequence
  burst_step_a: assert property (brd && !fast_read && reg_addr <= 8'h05
    |=> next_addr == $past(reg_addr) + 8'h01) else $error("burst step wrong");
  fast_skip_a: assert property (brd && fast_read && (reg_addr == 8'h01 || reg_addr == 8'h03)
    |=> next_addr == $past(reg_addr) + 8'h02) else $error("fast step wrong");
  buf_zero_a: assert property (reg_rd && mode != 2'b00 && reg_addr >= 8'h02
    && reg_addr <= 8'h06 |=> reg_rdata == 8'h00) else $error("low reads not zero");
  head_stay_a: assert property (reg_rd && reg_burst && mode != 2'b00 && reg_addr == 8'h01
    |=> next_addr == 8'h01) else $error("head address moved");
  fs_write_a: assert property (cfg_wr ##0 reg_wdata[1:0] != 2'b11
    |=> full_scale_select == $past(reg_wdata[1:0])) else $error("range not stored");
  fs_rsvd_a: assert property (cfg_wr ##0 reg_wdata[1:0] == 2'b11
    |=> $stable(full_scale_select)) else $error("reserved range stored");
  hpf_write_a: assert property (cfg_wr ##0 reg_wdata[1:0] != 2'b11
    |=> hpf_select == $past(reg_wdata[4])) else $error("filter bit not stored");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
endmodule // asfo_chk
bind asfo_core asfo_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_burst(reg_burst), .reg_wr(reg_wr), .fast_read(fast_read), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .next_addr(next_addr),
  .full_scale_select(full_scale_select), .hpf_select(hpf_select));

// *** bench/asfo_host.sv ***
// Purpose: Host side of the byte register port
// Assumes: Requests start 1 ns after a rising edge
// Notes:   Data taken one cycle after the request edge
`timescale 1ns/1ps
module asfo_host (
  input  wire       sys_clk,
  output reg        reg_rd,
  output reg        reg_burst,
  output reg        reg_wr,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata,
  input  wire [7:0] next_addr
);
  initial begin
    {reg_rd, reg_burst, reg_wr, reg_addr, reg_wdata} = 19'h0;
  end
  task rd(input [7:0] a, input b, output [7:0] d, output [7:0] n);
    begin
      @(posedge sys_clk) #1;
      {reg_rd, reg_burst, reg_addr} = {1'b1, b, a};
      @(posedge sys_clk) #1;
      reg_rd = 1'b0;
      d = reg_rdata;
      n = next_addr;
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge sys_clk) #1;
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
      @(posedge sys_clk) #1;
      reg_wr = 1'b0;
    end
  endtask
endmodule // asfo_host

// *** bench/asfo_core_test.sv ***
// Purpose: Self-checking bench of the sample buffer block
// Assumes: Host model drives the register port
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module asfo_core_test;
  reg         sys_clk, rst_n, sample_valid, fast_read, go_active;
  reg  [13:0] vx, vy, vz;
  reg  [7:0]  d, n;
  wire        sample_ready, reg_rd, reg_burst, reg_wr, hpf_select;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata, next_addr;
  wire [1:0]  full_scale_select;
  integer     errors, checks_done, i, j;
  asfo_core dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .raw_x(vx), .raw_y(vy), .raw_z(vz), .hpf_x(~vx),
    .hpf_y(~vy), .hpf_z(~vz), .fast_read(fast_read), .rate_change(1'b0),
    .go_active(go_active), .sleep_enter(1'b0), .sleep_gate(1'b0), .trigger_in(1'b0),
    .reg_rd(reg_rd), .reg_burst(reg_burst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .next_addr(next_addr),
    .full_scale_select(full_scale_select), .hpf_select(hpf_select), .gate_error(),
    .data_ready_status());
  asfo_host host_u (.sys_clk(sys_clk), .reg_rd(reg_rd), .reg_burst(reg_burst),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .next_addr(next_addr));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function [7:0] hi(input [13:0] v); hi = v[13:6]; endfunction
  function [7:0] lo(input [13:0] v); lo = {v[5:0], 2'b00}; endfunction
  task conclude;
    begin
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [8*6-1:0] nm, input [7:0] e, input [7:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task tick(input integer c);
    begin
      repeat (c) @(posedge sys_clk);
      #1;
    end
  endtask
  task rc(input [7:0] a, input b, input [7:0] e);
    begin
      host_u.rd(a, b, d, n);
      chk("rdata", e, d);
    end
  endtask
  // Y and Z follow X by fixed offsets
  task push(input [13:0] x);
    begin
      {vx, vy, vz, sample_valid} = {x, x + 14'h0111, x + 14'h0222, 1'b1};
      for (i = 0; i < 50 && sample_ready !== 1'b1; i = i + 1)
        tick(1);
      if (i == 50) begin
        errors = errors + 1;
        conclude;
      end
      tick(1);
      sample_valid = 1'b0;
    end
  endtask
  task burst(input [13:0] x);
    reg [13:0] v;
    integer    k;
    begin
      n = 8'h01;
      for (k = 0; k < 6; k = k + (fast_read ? 2 : 1)) begin
        v = x + (k / 2) * 14'h0111;
        host_u.rd(n, 1'b1, d, n);
        chk("burst", (k % 2) ? lo(v) : hi(v), d);
      end
      if (fast_read)
        chk("wrap", 8'h00, n);
    end
  endtask
  initial begin
    {errors, checks_done, rst_n, sample_valid, fast_read, go_active} = 0;
    {vx, vy, vz} = 42'h0;
    tick(4);
    rst_n = 1'b1;
    rc(8'h09, 1'b0, 8'h00);
    rc(8'h0e, 1'b0, 8'h00);
    rc(8'h20, 1'b0, 8'h00);
    push(14'h2abc);
    tick(4);
    burst(14'h2abc);
    fast_read = 1'b1;
    burst(14'h2abc);
    rc(8'h04, 1'b0, lo(14'h2bcd));
    fast_read = 1'b0;
    host_u.wr(8'h0e, 8'h11);
    push(14'h1234);
    tick(4);
    rc(8'h01, 1'b0, hi(~14'h1234));
    host_u.wr(8'h0e, 8'h03);
    chk("range", 8'h01, {6'h00, full_scale_select});
    for (j = 0; j < 3; j = j + 1) begin
      host_u.wr(8'h0e, j[7:0]);
      chk("range", j[7:0], {6'h00, full_scale_select});
    end
    host_u.wr(8'h09, 8'hc0);
    rc(8'h03, 1'b0, 8'h00);
    host_u.wr(8'h09, 8'h00);
    host_u.wr(8'h09, 8'h83);
    for (j = 1; j < 5; j = j + 1)
      push({j[7:0], 6'h00});
    tick(4);
    rc(8'h08, 1'b0, 8'h44);
    rc(8'h01, 1'b1, 8'h01);
    rc(8'h02, 1'b0, 8'h00);
    tick(2);
    rc(8'h08, 1'b0, 8'h43);
    host_u.wr(8'h09, 8'h00);
    tick(2);
    rc(8'h08, 1'b0, 8'h00);
    host_u.wr(8'h09, 8'h40);
    for (j = 1; j < 34; j = j + 1)
      push({j[7:0], 6'h00});
    tick(4);
    rc(8'h08, 1'b0, 8'ha0);
    rc(8'h01, 1'b0, 8'h02);
    go_active = 1'b1;
    tick(1);
    go_active = 1'b0;
    tick(2);
    rc(8'h08, 1'b0, 8'h00);
    conclude;
  end
endmodule // asfo_core_test
